// ---- design/pfta_map.svh ----
// register offsets, field positions, key values, command codes and timing counts
`ifndef PFTA_MAP_SVH
`define PFTA_MAP_SVH
`define PFTA_OFF_TBLPAGE   12'h000
`define PFTA_OFF_VISPAGE   12'h004
`define PFTA_OFF_NVCTRL    12'h008
`define PFTA_OFF_KEY       12'h00c
`define PFTA_OFF_TBLCMD    12'h010
`define PFTA_OFF_LATCH     12'h014
`define PFTA_OFF_ADDR      12'h018
`define PFTA_OFF_FETCH     12'h01c
`define PFTA_OFF_PROGADDR  12'h020
`define PFTA_OFF_VISADDR   12'h024
`define PFTA_OFF_PROGDATA  12'h028
`define PFTA_NVOP_WORD     4'h3
`define PFTA_NVOP_LSB      0
`define PFTA_NVOP_MSB      3
`define PFTA_WR_BIT        15
`define PFTA_WREN_BIT      14
`define PFTA_KEY_FIRST     8'h55
`define PFTA_KEY_SECOND    8'haa
`define PFTA_CFG_BIT       23
`define PFTA_PROG_TIME_NS  4000
`define PFTA_CLK_NS        4
`define PFTA_PROG_CYCLES   ((`PFTA_PROG_TIME_NS + `PFTA_CLK_NS - 1) / `PFTA_CLK_NS)
`define PFTA_CMD_RDLO      2'h0
`define PFTA_CMD_RDHI      2'h1
`define PFTA_CMD_WRLO      2'h2
`define PFTA_CMD_WRHI      2'h3
`endif

// ---- design/pfta_pkg.sv ----
// types shared by the table access block
package pfta_pkg;
  typedef enum logic [1:0] {
    PFTA_SEL_FETCH,
    PFTA_SEL_TABLE,
    PFTA_SEL_VIS
  } pfta_sel_t;
  typedef enum {
    PFTA_ST_IDLE,
    PFTA_ST_KEY1,
    PFTA_ST_ARMED,
    PFTA_ST_BUSY
  } pfta_state_t;
endpackage

// ---- design/pfta_addr_gen.sv ----
// program-space address former for fetch, table and visibility accesses
`timescale 1ns/100ps
`include "pfta_map.svh"
module pfta_addr_gen
  import pfta_pkg::*;
(
  // selection
  input wire pfta_sel_t sel,
  // sources
  input wire logic [22:0] program_counter,
  input wire logic [7:0] table_page_reg,
  input wire logic [7:0] visibility_page_reg,
  input wire logic [15:0] effective_address,
  // result
  output logic [23:0] prog_addr,
  output logic cfg_space
);
  always_comb begin
    case (sel)
      PFTA_SEL_TABLE: begin
        // byte address passes untouched, no alignment demanded
        prog_addr = {table_page_reg, effective_address}; // (R2) (R3) (R6)
      end
      PFTA_SEL_VIS: begin
        // ea bit 15 is the window marker and takes no part
        prog_addr = {1'b0, visibility_page_reg[7:1], visibility_page_reg[0],
                     effective_address[14:1], 1'b0}; // (R4) (R5) (R1)
      end
      default: begin
        prog_addr = {1'b0, program_counter[22:1], 1'b0}; // (R1)
      end
    endcase
    cfg_space = (sel == PFTA_SEL_TABLE) && prog_addr[`PFTA_CFG_BIT]; // (R18) (R7)
  end
endmodule

// ---- design/pfta_core.sv ----
// table access, address forming and single-word flash programming
// Functional notes
// (R1) fetch, visibility and programming addresses have bit 0 forced to zero
// (R2) table accesses take address bits 23..16 from the table page register
// (R3) table accesses take address bits 15..0 from the effective address
// (R4) visibility uses page bit 0 as address bit 15, ea 14..1 below
// (R5) effective address bit 15 is ignored in visibility accesses
// (R6) table reads and writes accept any byte address
// (R7) table reads may reach configuration space
// (R8) software programs only erased locations
// (R9) one 24-bit write latch holds the word to program
// (R10) low write loads 16 bits, high write loads the upper 8 bits
// (R11) operation field 0011 in control bits 3..0 selects word programming
// (R12) software sets the control register to 0x4003 for word programming
// (R13) key register must see 0x55 then 0xaa
// (R14) programming starts only when start follows a completed key pair
// (R15) software blocks interrupts during the key sequence
// (R16) software runs two no-ops after setting start
// (R17) start without key is ignored; start self-clears when programming ends
// (R18) address bit 23 high selects configuration space, else user space
`timescale 1ns/100ps
`include "pfta_map.svh"
module pfta_core
  import pfta_pkg::*;
#(
  parameter int PROG_CYCLES = `PFTA_PROG_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // code fetch
  input wire logic [22:0] program_counter,
  // flash array port
  output logic [23:0] flash_addr,
  output logic [23:0] flash_wdata,
  output logic flash_prog,
  output logic flash_cfg,
  input wire logic [23:0] flash_rdata
);
  logic [7:0] table_page_reg_q;
  logic [7:0] visibility_page_reg_q;
  logic [15:0] nv_control_reg_q;
  logic [23:0] latch_q;
  logic [15:0] ea_q;
  logic [23:0] rdword_q;
  logic [23:0] prog_addr_q;
  logic [23:0] fetch_addr;
  logic [23:0] table_addr;
  logic [23:0] vis_addr;
  logic table_cfg;
  pfta_state_t state_q;
  logic [31:0] cnt_q;
  logic setup;
  logic wr_en;
  logic rd_en;
  logic [11:0] wr_addr;
  logic [1:0] cmd;
  logic start_req;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = setup && !pwrite;
  assign wr_addr = paddr;
  assign cmd = pwdata[1:0];
  assign start_req = wr_en && (wr_addr == `PFTA_OFF_NVCTRL) && pwdata[`PFTA_WR_BIT];

  pfta_addr_gen u_fetch (
    .sel(PFTA_SEL_FETCH),
    .program_counter(program_counter),
    .table_page_reg(table_page_reg_q),
    .visibility_page_reg(visibility_page_reg_q),
    .effective_address(ea_q),
    .prog_addr(fetch_addr),
    .cfg_space()
  );

  pfta_addr_gen u_table (
    .sel(PFTA_SEL_TABLE),
    .program_counter(program_counter),
    .table_page_reg(table_page_reg_q),
    .visibility_page_reg(visibility_page_reg_q),
    .effective_address(ea_q),
    .prog_addr(table_addr),
    .cfg_space(table_cfg)
  );

  pfta_addr_gen u_vis (
    .sel(PFTA_SEL_VIS),
    .program_counter(program_counter),
    .table_page_reg(table_page_reg_q),
    .visibility_page_reg(visibility_page_reg_q),
    .effective_address(ea_q),
    .prog_addr(vis_addr),
    .cfg_space()
  );

  // zero-wait slave: every access completes in its first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && (paddr[1:0] != 2'h0 || paddr > `PFTA_OFF_PROGDATA);
    end
  end

  // page registers and the table offset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_page_reg_q <= 8'h00;
      visibility_page_reg_q <= 8'h00;
      ea_q <= 16'h0000;
    end else if (wr_en) begin
      case (wr_addr)
        `PFTA_OFF_TBLPAGE: table_page_reg_q <= pwdata[7:0]; // (R2)
        `PFTA_OFF_VISPAGE: visibility_page_reg_q <= pwdata[7:0]; // (R4)
        `PFTA_OFF_ADDR: ea_q <= pwdata[15:0]; // (R3) (R6)
        default: ;
      endcase
    end
  end

  // write latch and table reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= 24'h000000;
      rdword_q <= 24'h000000;
    end else if (wr_en && wr_addr == `PFTA_OFF_TBLCMD) begin
      case (cmd)
        `PFTA_CMD_WRLO: latch_q[15:0] <= pwdata[31:16]; // (R9) (R10)
        `PFTA_CMD_WRHI: latch_q[23:16] <= pwdata[23:16]; // (R10)
        // reads reach user and configuration space alike
        default: rdword_q <= flash_rdata; // (R7)
      endcase
    end
  end

  // unlock, arm and programming sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= PFTA_ST_IDLE;
      cnt_q <= 32'h0;
      prog_addr_q <= 24'h000000;
    end else begin
      case (state_q)
        PFTA_ST_IDLE: begin
          if (wr_en && wr_addr == `PFTA_OFF_KEY && pwdata[7:0] == `PFTA_KEY_FIRST) begin
            state_q <= PFTA_ST_KEY1; // (R13)
          end
        end
        PFTA_ST_KEY1: begin
          if (wr_en) begin
            // any other write between the two keys breaks the pair
            if (wr_addr == `PFTA_OFF_KEY && pwdata[7:0] == `PFTA_KEY_SECOND) begin
              state_q <= PFTA_ST_ARMED; // (R13)
            end else begin
              state_q <= PFTA_ST_IDLE;
            end
          end
        end
        PFTA_ST_ARMED: begin
          if (wr_en) begin
            if (start_req && pwdata[`PFTA_NVOP_MSB:`PFTA_NVOP_LSB] == `PFTA_NVOP_WORD
                && pwdata[`PFTA_WREN_BIT]) begin
              state_q <= PFTA_ST_BUSY; // (R14) (R11)
              cnt_q <= PROG_CYCLES - 1;
              prog_addr_q <= {table_addr[23:1], 1'b0}; // (R1)
            end else begin
              state_q <= PFTA_ST_IDLE; // (R17)
            end
          end
        end
        PFTA_ST_BUSY: begin
          if (cnt_q == 32'h0) begin
            state_q <= PFTA_ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        default: state_q <= PFTA_ST_IDLE;
      endcase
    end
  end

  // control register; start bit only sets when armed, clears at the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_control_reg_q <= 16'h0000;
    end else if (wr_en && wr_addr == `PFTA_OFF_NVCTRL && state_q != PFTA_ST_BUSY) begin
      nv_control_reg_q <= {pwdata[`PFTA_WR_BIT] && state_q == PFTA_ST_ARMED
                           && pwdata[`PFTA_NVOP_MSB:`PFTA_NVOP_LSB] == `PFTA_NVOP_WORD
                           && pwdata[`PFTA_WREN_BIT], pwdata[14:0]}; // (R17) (R11)
    end else if (state_q == PFTA_ST_BUSY && cnt_q == 32'h0) begin
      nv_control_reg_q[`PFTA_WR_BIT] <= 1'b0; // (R17)
    end
  end

  // read mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      case (paddr)
        `PFTA_OFF_TBLPAGE: prdata <= {24'h0, table_page_reg_q};
        `PFTA_OFF_VISPAGE: prdata <= {24'h0, visibility_page_reg_q};
        `PFTA_OFF_NVCTRL: prdata <= {16'h0, nv_control_reg_q};
        `PFTA_OFF_LATCH: prdata <= {8'h0, latch_q};
        `PFTA_OFF_ADDR: prdata <= {16'h0, ea_q};
        `PFTA_OFF_FETCH: prdata <= {8'h0, fetch_addr};
        `PFTA_OFF_PROGADDR: prdata <= {7'h0, table_cfg, table_addr};
        `PFTA_OFF_VISADDR: prdata <= {8'h0, vis_addr};
        `PFTA_OFF_PROGDATA: prdata <= {8'h0, rdword_q};
        default: prdata <= 32'h0;
      endcase
    end else begin
      prdata <= 32'h0;
    end
  end

  // flash port, registered so the array sees stable values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_addr <= 24'h000000;
      flash_wdata <= 24'h000000;
      flash_prog <= 1'b0;
      flash_cfg <= 1'b0;
    end else begin
      flash_addr <= (state_q == PFTA_ST_BUSY) ? prog_addr_q : table_addr;
      flash_wdata <= latch_q;
      flash_prog <= (state_q == PFTA_ST_BUSY); // (R14)
      flash_cfg <= (state_q == PFTA_ST_BUSY) ? prog_addr_q[`PFTA_CFG_BIT] : table_cfg; // (R18)
    end
  end

  // address forming
  a_fetch_align: assert property (@(posedge pclk) disable iff (!presetn) // (R1)
    fetch_addr[0] == 1'b0 && vis_addr[0] == 1'b0)
    else $error("formed address not word aligned");
  a_fetch_pc: assert property (@(posedge pclk) disable iff (!presetn) // (R1)
    fetch_addr[23] == 1'b0 && fetch_addr[22:1] == program_counter[22:1])
    else $error("fetch address not taken from counter");
  a_table_page: assert property (@(posedge pclk) disable iff (!presetn) // (R2)
    table_addr[23:16] == table_page_reg_q)
    else $error("table page not in upper byte");
  a_table_low: assert property (@(posedge pclk) disable iff (!presetn) // (R3) (R6)
    table_addr[15:0] == ea_q)
    else $error("table low bits differ from offset");
  a_vis_bits: assert property (@(posedge pclk) disable iff (!presetn) // (R4) (R5)
    vis_addr[15] == visibility_page_reg_q[0] && vis_addr[14:1] == ea_q[14:1])
    else $error("visibility address wrong");
  a_vis_page: assert property (@(posedge pclk) disable iff (!presetn) // (R4)
    vis_addr[23] == 1'b0 && vis_addr[22:15] == visibility_page_reg_q)
    else $error("visibility page misplaced");
  a_cfg_route: assert property (@(posedge pclk) disable iff (!presetn) // (R18)
    table_cfg == table_addr[23])
    else $error("configuration routing wrong");
  a_port_cfg: assert property (@(posedge pclk) disable iff (!presetn) // (R18)
    flash_cfg == flash_addr[`PFTA_CFG_BIT])
    else $error("space select differs from port address");

  // bus answer; zero wait, so every answer lasts exactly one cycle
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held past one cycle");
  a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0)
    else $error("read data outside access cycle");

  // write latch and table reads
  a_latch_lo: assert property (@(posedge pclk) disable iff (!presetn) // (R10)
    wr_en && wr_addr == `PFTA_OFF_TBLCMD && cmd == `PFTA_CMD_WRLO
    |=> latch_q[15:0] == $past(pwdata[31:16]))
    else $error("low latch write lost");
  a_latch_hi: assert property (@(posedge pclk) disable iff (!presetn) // (R10)
    wr_en && wr_addr == `PFTA_OFF_TBLCMD && cmd == `PFTA_CMD_WRHI
    |=> latch_q[23:16] == $past(pwdata[23:16]))
    else $error("high latch write lost");
  a_latch_keep: assert property (@(posedge pclk) disable iff (!presetn) // (R10)
    wr_en && wr_addr == `PFTA_OFF_TBLCMD && cmd == `PFTA_CMD_WRHI
    |=> latch_q[15:0] == $past(latch_q[15:0]))
    else $error("high write disturbed low latch");
  a_rd_capture: assert property (@(posedge pclk) disable iff (!presetn) // (R7)
    wr_en && wr_addr == `PFTA_OFF_TBLCMD && (cmd == `PFTA_CMD_RDLO || cmd == `PFTA_CMD_RDHI)
    |=> rdword_q == $past(flash_rdata))
    else $error("table read word not captured");
  a_wdata_copy: assert property (@(posedge pclk) disable iff (!presetn) // (R9)
    flash_wdata == $past(latch_q))
    else $error("latch not on write port");

  // unlock and programming; a broken sequence must fall back to idle
  a_key_pair: assert property (@(posedge pclk) disable iff (!presetn) // (R13)
    $rose(state_q == PFTA_ST_ARMED) |-> $past(state_q) == PFTA_ST_KEY1)
    else $error("armed without key pair");
  a_key_break: assert property (@(posedge pclk) disable iff (!presetn) // (R13)
    state_q == PFTA_ST_KEY1 && wr_en
    && !(wr_addr == `PFTA_OFF_KEY && pwdata[7:0] == `PFTA_KEY_SECOND)
    |=> state_q == PFTA_ST_IDLE)
    else $error("broken key pair kept");
  a_armed_break: assert property (@(posedge pclk) disable iff (!presetn) // (R17)
    state_q == PFTA_ST_ARMED && wr_en && !start_req |=> state_q == PFTA_ST_IDLE)
    else $error("arming survived another write");
  a_start_armed: assert property (@(posedge pclk) disable iff (!presetn) // (R14)
    $rose(flash_prog) |-> $past(state_q, 2) == PFTA_ST_ARMED)
    else $error("programming began unarmed");
  a_start_set: assert property (@(posedge pclk) disable iff (!presetn) // (R14)
    $rose(state_q == PFTA_ST_BUSY)
    |-> nv_control_reg_q[`PFTA_WR_BIT] && nv_control_reg_q[`PFTA_WREN_BIT])
    else $error("busy without start bit");
  a_prog_op: assert property (@(posedge pclk) disable iff (!presetn) // (R11)
    $rose(state_q == PFTA_ST_BUSY)
    |-> nv_control_reg_q[`PFTA_NVOP_MSB:`PFTA_NVOP_LSB] == `PFTA_NVOP_WORD)
    else $error("busy without word operation");
  a_prog_len: assert property (@(posedge pclk) disable iff (!presetn) // (R17)
    $rose(flash_prog) |-> flash_prog [*8])
    else $error("programming pulse too short");
  a_prog_addr: assert property (@(posedge pclk) disable iff (!presetn) // (R1)
    flash_prog |-> flash_addr == prog_addr_q && flash_addr[0] == 1'b0)
    else $error("programming address wrong");
  a_start_refused: assert property (@(posedge pclk) disable iff (!presetn) // (R17)
    wr_en && wr_addr == `PFTA_OFF_NVCTRL
    && (state_q == PFTA_ST_IDLE || state_q == PFTA_ST_KEY1)
    |=> !nv_control_reg_q[`PFTA_WR_BIT])
    else $error("start bit set without keys");
  a_busy_lock: assert property (@(posedge pclk) disable iff (!presetn) // (R17)
    state_q == PFTA_ST_BUSY && cnt_q != 32'h0 && wr_en && wr_addr == `PFTA_OFF_NVCTRL
    |=> nv_control_reg_q == $past(nv_control_reg_q))
    else $error("control changed while programming");
  a_wr_clear: assert property (@(posedge pclk) disable iff (!presetn) // (R17)
    $fell(state_q == PFTA_ST_BUSY) |-> !nv_control_reg_q[`PFTA_WR_BIT])
    else $error("start bit not cleared");
endmodule

// ---- verification/pfta_flash_model.sv ----
// flash array stand-in that answers table reads and takes programmed words
`timescale 1ns/100ps
module pfta_flash_model (
  // clock
  input wire logic pclk,
  // array port
  input wire logic [23:0] flash_addr,
  input wire logic [23:0] flash_wdata,
  input wire logic flash_prog,
  input wire logic flash_cfg,
  output logic [23:0] flash_rdata
);
  logic prog_q = 1'b0;
  logic word_valid_q = 1'b0;
  logic [23:0] word_addr_q = 24'h000000;
  logic [23:0] word_data_q = 24'h000000;
  logic word_cfg_q = 1'b0;
  // only the last programmed word is kept, enough for one program-then-read check
  always @(posedge pclk) begin
    prog_q <= flash_prog;
    if (flash_prog && !prog_q) begin
      word_valid_q <= 1'b1;
      word_addr_q <= flash_addr;
      word_data_q <= flash_wdata;
      word_cfg_q <= flash_cfg;
    end
  end
  // other cells read as the inverted address so a wrong address shows
  assign flash_rdata = (word_valid_q && flash_addr == word_addr_q && flash_cfg == word_cfg_q) ?
    word_data_q : ~flash_addr;
endmodule

// ---- verification/test_program_flash_table_access.sv ----
// register-level test of the table access and word programming block
`timescale 1ns/100ps
module test_program_flash_table_access
  import pfta_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, flash_prog, flash_cfg, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [22:0] program_counter;
  logic [23:0] flash_addr, flash_wdata, flash_rdata, ta;
  logic [7:0] pg;
  logic [15:0] ea;
  int bad_count = 0;
  int tests_run = 0;
  int n;
  localparam int PROG_LEN = 10;
  always #2 pclk = ~pclk;
  pfta_core #(.PROG_CYCLES(PROG_LEN)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .program_counter(program_counter),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_prog(flash_prog),
    .flash_cfg(flash_cfg), .flash_rdata(flash_rdata));
  pfta_flash_model flash (.pclk(pclk), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_prog(flash_prog), .flash_cfg(flash_cfg), .flash_rdata(flash_rdata));
  task test_done;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("Error %0t: no pready", $time);
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp, what);
  endtask
  // waits for the programming strobe to reach a level, counting edges
  task wait_prog(input logic lvl, input int lim);
    n = 0;
    while (flash_prog !== lvl && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (flash_prog !== lvl) begin
      bad_count++;
      $display("Error %0t: programming strobe timeout", $time);
      test_done();
    end
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    program_counter = 23'h5abcd5;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h01c, 32'h005abcd4, "fetch address");
    // odd effective address on purpose: table access keeps the byte address
    for (int i = 0; i < 2; i++) begin
      pg = (i == 0) ? 8'h85 : 8'h12;
      ea = 16'h1235;
      ta = {pg, ea};
      wr(12'h000, {24'h0, pg});
      wr(12'h018, {16'h0, ea});
      wr(12'h010, 32'(i));
      rdc(12'h020, {7'h0, pg[7], ta}, "table address");
      chk(flash_addr, ta, "flash address");
      chk(flash_cfg, pg[7], "space select");
      rdc(12'h028, {8'h0, ~ta}, "table read word");
    end
    wr(12'h004, 32'h00000037);
    for (int i = 0; i < 2; i++) begin
      ea = (i == 0) ? 16'h42a7 : 16'hc2a7;
      wr(12'h018, {16'h0, ea});
      rdc(12'h024, {8'h0, 1'b0, 8'h37, ea[14:1], 1'b0}, "visibility address");
    end
    wr(12'h010, 32'hbeef0002);
    wr(12'h010, 32'h009c0003);
    rdc(12'h014, 32'h009cbeef, "write latch");
    chk(flash_wdata, 24'h9cbeef, "latch port");
    wr(12'h008, 32'h00004003);
    wr(12'h008, 32'h0000c003);
    rdc(12'h008, 32'h00004003, "start without key");
    wr(12'h00c, 32'h000000aa);
    wr(12'h00c, 32'h00000055);
    wr(12'h008, 32'h0000c003);
    rdc(12'h008, 32'h00004003, "keys reversed");
    wr(12'h00c, 32'h00000055);
    wr(12'h00c, 32'h000000aa);
    wr(12'h000, 32'h00000001);
    wr(12'h008, 32'h0000c003);
    rdc(12'h008, 32'h00004003, "key pair broken");
    chk(flash_prog, 1'b0, "no programming");
    // host side keeps the order tight, as it would with interrupts blocked
    wr(12'h018, 32'h00002344);
    wr(12'h00c, 32'h00000055);
    wr(12'h00c, 32'h000000aa);
    wr(12'h008, 32'h0000c003);
    // the idle edges of this wait stand in for the host's two no-ops
    wait_prog(1'b1, 20);
    chk(n, 2, "programming start delay");
    chk(flash_prog, 1'b1, "programming started");
    chk(flash_addr, 24'h012344, "program address");
    wr(12'h008, 32'h00000000);
    rdc(12'h008, 32'h0000c003, "start bit while busy");
    wait_prog(1'b0, 100);
    // six edges of the strobe went by during the two transfers above
    chk(n, PROG_LEN - 6, "programming length");
    rdc(12'h008, 32'h00004003, "start self clears");
    wr(12'h010, 32'h00000000);
    rdc(12'h028, 32'h009cbeef, "programmed word");
    rdc(12'h02c, 32'h00000000, "unmapped read");
    chk(er, 1'b1, "unmapped error");
    rdc(12'h002, 32'h00000000, "unaligned read");
    chk(er, 1'b1, "unaligned error");
    test_done();
  end
endmodule
